// ===== dv/sdr_assertions.sv
// Port checks for the serializer
`timescale 1ns/1ps
`default_nettype none
module sdr_assertions
	import sdr_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	// Clocks, lock, power
	input wire logic divided_rate_out,
	input wire logic reference_in,
	input wire logic lock_indicator,
	input wire sdr_osc_t osc_power,
	input wire sdr_fast_clk_t fast_clock_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [6:0] gap_q;
	// Saturates so a dead reference never wraps to a small gap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) gap_q <= 7'h00;
		else gap_q <= $rose(reference_in) ? 7'h00 : gap_q + 7'(gap_q != 7'h7F);
	end
	chk_word_high: assert property ($rose(divided_rate_out) |-> ##8 $fell(divided_rate_out))
		else $error("word clock high not 8");
	chk_word_low: assert property ($fell(divided_rate_out) |-> ##8 $rose(divided_rate_out))
		else $error("word clock low not 8");
	chk_osc_one: assert property ($past(presetn) |-> osc_power.osc_11g0_enable != osc_power.osc_11g8_enable)
		else $error("oscillator enables not one-hot");
	// Two edges of history: the first edge after release still loads zero from the divider
	chk_half_toggle: assert property ($past(presetn, 2) |-> fast_clock_out.fast_clock_half != $past(fast_clock_out.fast_clock_half))
		else $error("half-rate clock not toggling");
	chk_lock_drop: assert property (gap_q > 7'd40 |-> !lock_indicator)
		else $error("lock held without reference");
	chk_pready_once: assert property (psel && penable && !pready |=> pready)
		else $error("no answer after one wait");
	chk_pready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_rd_zero: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
endmodule // sdr_assertions
`default_nettype wire

// ===== dv/sdr_serializer_tb_top.sv
// Self-checking bench for the serializer
`timescale 1ns/1ps
`default_nettype none
module sdr_serializer_tb_top
	import sdr_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ref_en = 1;
	logic pready, pslverr, err_v, divided_rate_out, reference_in, lock_indicator, serial_data_out, irq;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd_v;
	logic [15:0] parallel_data_in, word = 16'h0, sh = 16'h0;
	logic [3:0] phase;
	sdr_fast_clk_t fast_clock_out;
	sdr_osc_t osc_power;
	int failures = 0, comparisons = 0, cyc = 0;
	logic [3:0] ctl [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hC};
	logic [15:0] wd [6] = '{16'h1234, 16'h1234, 16'hA5C3, 16'h0F31, 16'hFFFE, 16'h7001};
	logic [3:0] ex [6] = '{4'h5, 4'h5, 4'h9, 4'h7, 4'h4, 4'h5};
	sdr_serializer sdr_serializer_inst (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.parallel_data_in(parallel_data_in),
		.divided_rate_out(divided_rate_out),
		.reference_in(reference_in),
		.lock_indicator(lock_indicator),
		.serial_data_out(serial_data_out),
		.fast_clock_out(fast_clock_out),
		.osc_power(osc_power),
		.irq(irq)
	);
	sdr_source_model sdr_source_model_inst (
		.pclk(pclk),
		.presetn(presetn),
		.word(word),
		.ref_en(ref_en),
		.phase(phase),
		.parallel_data_in(parallel_data_in),
		.reference_in(reference_in)
	);
	initial begin
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		sh <= {sh[14:0], serial_data_out};
		cyc++;
		if (cyc == 5000) begin
			failures++;
			summarize();
		end
	end
	task automatic summarize();
		if (failures == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Returns just after the edge that completes a word on the serial line
	task automatic wait_ph();
		do begin
			@(posedge pclk);
			#1;
		end while (phase != 4'h2);
	endtask
	function automatic logic [15:0] rev(input logic [15:0] v);
		for (int k = 0; k < 16; k++) rev[k] = v[15 - k];
	endfunction
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFF_CTRL, 32'h0);
		cmp(rd_v, 32'h0);
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, OFF_CTRL, 32'(ctl[i]));
			word <= wd[i];
			repeat (3) wait_ph();
			cmp(32'(sh), 32'(ctl[i][0] ? wd[i] : rev(wd[i])));
			cmp(32'({osc_power, fast_clock_out[1:0]}), 32'(ex[i]));
		end
		apb(1'b0, OFF_STATE, 32'h0);
		cmp(rd_v, 32'h1);
		apb(1'b1, OFF_IRQ_ENABLE, 32'h3);
		apb(1'b1, OFF_IRQ_CLEAR, 32'h3);
		repeat (3) @(posedge pclk);
		cmp(32'(irq), 32'h0);
		ref_en <= 1'b0;
		repeat (60) @(posedge pclk);
		cmp(32'(lock_indicator), 32'h0);
		apb(1'b0, OFF_IRQ_STATUS, 32'h0);
		cmp(rd_v, 32'h2);
		cmp(32'(irq), 32'h1);
		apb(1'b1, OFF_IRQ_CLEAR, 32'h2);
		apb(1'b0, 8'h20, 32'h0);
		cmp({rd_v[30:0], err_v}, 32'h1);
		cmp(32'(irq), 32'h0);
		// Mid-run reset: outputs clear at once and control returns to its defaults
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		cmp(32'({osc_power, divided_rate_out, lock_indicator, irq}), 32'h0);
		presetn <= 1'b1;
		apb(1'b0, OFF_CTRL, 32'h0);
		cmp(rd_v, 32'h0);
		cmp(32'(osc_power), 32'h1);
		summarize();
	end
endmodule // sdr_serializer_tb_top
bind sdr_serializer sdr_assertions sdr_assertions_inst (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pready(pready),
	.pslverr(pslverr),
	.prdata(prdata),
	.divided_rate_out(divided_rate_out),
	.reference_in(reference_in),
	.lock_indicator(lock_indicator),
	.osc_power(osc_power),
	.fast_clock_out(fast_clock_out)
);
`default_nettype wire

// ===== dv/sdr_source_model.sv
// Parallel word source and reference clock
`timescale 1ns/1ps
`default_nettype none
module sdr_source_model
	import sdr_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench control
	input wire logic [WORD_W-1:0] word,
	input wire logic ref_en,
	output logic [3:0] phase,
	// Device side
	output logic [WORD_W-1:0] parallel_data_in,
	output logic reference_in
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 4'h0;
			parallel_data_in <= '0;
			reference_in <= 1'b0;
		end else begin
			phase <= phase + 4'h1;
			// Mid-word update keeps data settled around capture
			if (phase == 4'h8) parallel_data_in <= word;
			if (phase == 4'h7) reference_in <= ref_en;
			if (phase == 4'hF) reference_in <= 1'b0;
		end
	end
endmodule // sdr_source_model
`default_nettype wire

// ===== inc/sdr_pkg.sv
// Constants and types for the 16-to-1 serializer with clock divider
package sdr_pkg;

	localparam int WORD_W = 16;
	localparam int DIV_STAGES = 4;

	// Full-rate clock period in ps and derived word period in cycles
	localparam int FULL_PERIOD_PS = 4000;
	localparam int WORD_CYCLES = 1 << DIV_STAGES;

	// Reference edges farther apart than this count as loss of lock
	localparam logic [5:0] REF_TIMEOUT = 6'h20;

	// Divider count at which the word-rate clock rises (7 -> 8)
	localparam logic [3:0] WORD_RISE_CNT = 4'h8;
	// Divider count at which the word-rate clock falls (15 -> 0)
	localparam logic [3:0] WORD_FALL_CNT = 4'h0;

	// APB register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATE = 8'h04;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h0C;
	localparam logic [7:0] OFF_IRQ_CLEAR = 8'h10;

	// Field positions
	localparam int CTRL_BIT_ORDER = 0;
	localparam int CTRL_VCO_BAND = 1;
	localparam int CTRL_HS_MODE_LO = 2;
	localparam int IRQ_LOCK_GAINED = 0;
	localparam int IRQ_LOCK_LOST = 1;
	localparam int IRQ_W = 2;

	typedef enum logic [1:0] {
		SDR_HS_HALF = 2'h0,
		SDR_HS_FULL = 2'h1,
		SDR_HS_OFF = 2'h2
	} sdr_hs_mode_t;

	typedef struct packed {
		sdr_hs_mode_t hs_clock_mode;
		logic vco_band_select;
		logic bit_order_select;
	} sdr_ctrl_t;

	localparam sdr_ctrl_t CTRL_RESET = '{hs_clock_mode: SDR_HS_HALF, vco_band_select: 1'b0,
		bit_order_select: 1'b0};

	typedef struct packed {
		logic fast_clock_half;
		logic fast_clock_full_sel;
		logic fast_clock_enable;
	} sdr_fast_clk_t;

	typedef struct packed {
		logic osc_11g0_enable;
		logic osc_11g8_enable;
	} sdr_osc_t;

endpackage

// ===== verilog/sdr_serializer.sv
// 16-to-1 serializer with divider chain, lock monitor and APB control
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module sdr_serializer
	import sdr_pkg::*;
#(
	parameter int WIDTH = WORD_W
) (
	// Clock and reset; pclk is the full-rate clock
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Parallel side
	input wire logic [WIDTH-1:0] parallel_data_in,
	output logic divided_rate_out,
	// Reference and lock
	input wire logic reference_in,
	output logic lock_indicator,
	// Serial side
	output logic serial_data_out,
	output sdr_fast_clk_t fast_clock_out,
	// Oscillator power control
	output sdr_osc_t osc_power,
	// Interrupt
	output logic irq
);

	sdr_ctrl_t ctrl_q;
	logic [DIV_STAGES-1:0] div_q;
	logic [WIDTH-1:0] shift_q;
	logic ref_prev_q;
	logic [5:0] ref_gap_q;
	logic lock_q;
	logic [IRQ_W-1:0] irq_status_q, irq_enable_q, irq_set;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;
	logic word_fall, ref_rise, bus_done, wr_en, addr_ok;
	logic [IRQ_W-1:0] clear_bits;

	function automatic logic [WIDTH-1:0] order_word(input logic [WIDTH-1:0] w, input logic rev);
		logic [WIDTH-1:0] r;
		r = '0;
		for (int i = 0; i < WIDTH; i++) begin
			r[WIDTH-1-i] = w[i];
		end
		return rev ? w : r;
	endfunction

	// Ripple of four toggle stages, modelled as one count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 4'h1;
		end
	end

	// Word clock is the top stage; it falls as the count wraps to zero
	assign word_fall = (div_q == WORD_FALL_CNT);

	// Shift register MSB leaves first; loaded word is out within one word period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_q <= '0;
		end else if (word_fall) begin
			shift_q <= order_word(parallel_data_in, ctrl_q.bit_order_select);
		end else begin
			shift_q <= {shift_q[WIDTH-2:0], 1'b0};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_data_out <= 1'b0;
			divided_rate_out <= 1'b0;
			fast_clock_out <= '0;
			osc_power <= '0;
		end else begin
			serial_data_out <= shift_q[WIDTH-1];
			divided_rate_out <= div_q[DIV_STAGES-1];
			fast_clock_out.fast_clock_half <= div_q[0];
			fast_clock_out.fast_clock_full_sel <= (ctrl_q.hs_clock_mode == SDR_HS_FULL);
			fast_clock_out.fast_clock_enable <= (ctrl_q.hs_clock_mode != SDR_HS_OFF);
			osc_power.osc_11g0_enable <= ctrl_q.vco_band_select;
			osc_power.osc_11g8_enable <= !ctrl_q.vco_band_select;
		end
	end

	// Lock: every reference rising edge must meet the word clock rising edge
	assign ref_rise = reference_in && !ref_prev_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_prev_q <= 1'b0;
			ref_gap_q <= '0;
			lock_q <= 1'b0;
		end else begin
			ref_prev_q <= reference_in;
			if (ref_rise) begin
				ref_gap_q <= '0;
				lock_q <= (div_q == WORD_RISE_CNT);
			end else if (ref_gap_q == REF_TIMEOUT) begin
				lock_q <= 1'b0;
			end else begin
				ref_gap_q <= ref_gap_q + 6'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_indicator <= 1'b0;
		end else begin
			lock_indicator <= lock_q;
		end
	end

	// APB: answer on the second access cycle so all bus outputs are registered
	assign bus_done = psel && penable && pready_q;
	assign wr_en = bus_done && pwrite;
	assign addr_ok = (paddr == OFF_CTRL) || (paddr == OFF_STATE) || (paddr == OFF_IRQ_STATUS)
		|| (paddr == OFF_IRQ_ENABLE) || (paddr == OFF_IRQ_CLEAR);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			pready_q <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && !addr_ok;
			prdata_q <= '0;
			if (psel && penable && !pready_q && !pwrite) begin
				case (paddr)
					OFF_CTRL: prdata_q <= {28'h0000000, ctrl_q};
					OFF_STATE: prdata_q <= {31'h00000000, lock_q};
					OFF_IRQ_STATUS: prdata_q <= {30'h00000000, irq_status_q};
					OFF_IRQ_ENABLE: prdata_q <= {30'h00000000, irq_enable_q};
					default: prdata_q <= '0;
				endcase
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr_en && paddr == OFF_CTRL) begin
			ctrl_q.bit_order_select <= pwdata[CTRL_BIT_ORDER];
			ctrl_q.vco_band_select <= pwdata[CTRL_VCO_BAND];
			// Code 3 is not a pin state; it falls back to the unconnected default
			ctrl_q.hs_clock_mode <= (pwdata[CTRL_HS_MODE_LO+:2] == 2'h3) ? SDR_HS_HALF
				: sdr_hs_mode_t'(pwdata[CTRL_HS_MODE_LO+:2]);
		end
	end

	// Sticky lock events; a set in the clearing cycle wins
	assign irq_set[IRQ_LOCK_GAINED] = lock_q == 1'b0 && ref_rise && div_q == WORD_RISE_CNT;
	assign irq_set[IRQ_LOCK_LOST] = lock_q && ((ref_rise && div_q != WORD_RISE_CNT) || ref_gap_q == REF_TIMEOUT);
	assign clear_bits = (wr_en && paddr == OFF_IRQ_CLEAR) ? pwdata[IRQ_W-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_q <= '0;
		end else begin
			irq_status_q <= (irq_status_q & ~clear_bits) | irq_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable_q <= '0;
		end else if (wr_en && paddr == OFF_IRQ_ENABLE) begin
			irq_enable_q <= pwdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_q & irq_enable_q);
		end
	end

endmodule // sdr_serializer

`default_nettype wire
